// file: logic/dmacc_fifo.sv
`timescale 1ns/1ps
module dmacc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  dmacc_fifo_if.fifo f
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic             push, pop;

  assign f.in_ready  = (cnt_r != DEPTH[AW:0]);
  assign f.out_valid = (cnt_r != '0);
  assign f.out_data  = mem_r[rp_r];
  assign push = f.in_valid & f.in_ready;
  assign pop  = f.out_valid & f.out_ready;

  always_comb begin
    wp_nxt  = push ? AW'(wp_r + 1'b1) : wp_r;
    rp_nxt  = pop ? AW'(rp_r + 1'b1) : rp_r;
    cnt_nxt = (AW+1)'(cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // storage carries no reset so it maps to plain flops without reset tree
  always_ff @(posedge pclk) begin
    if (push) begin
      mem_r[wp_r] <= f.in_data;
    end
  end

  fifo_count_a: assert property (@(posedge pclk) disable iff (!presetn)
    cnt_r <= DEPTH[AW:0]) else $error("fifo count above depth");
endmodule

// file: logic/dmacc_fifo_if.sv
`timescale 1ns/1ps
interface dmacc_fifo_if #(parameter int W = 8);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;
  modport fifo (input in_valid, in_data, out_ready,
                output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready,
                input in_ready, out_valid, out_data);
endinterface

// file: logic/dmacc_pkg.sv
package dmacc_pkg;
  // register byte offsets; aliases clear, set and invert bits written as 1
  localparam logic [7:0] CTRL_OFF     = 8'h00;
  localparam logic [7:0] CTRL_CLR_OFF = 8'h04;
  localparam logic [7:0] CTRL_SET_OFF = 8'h08;
  localparam logic [7:0] CTRL_INV_OFF = 8'h0C;
  localparam logic [7:0] STAT_OFF     = 8'h10;
  localparam logic [7:0] CHAIN_OFF    = 8'h14;
  localparam logic [7:0] EVT_OFF      = 8'h18;
  // control field positions
  localparam int IGN_LSB   = 24;
  localparam int BUSY_BIT  = 15;
  localparam int IGNEN_BIT = 13;
  localparam int PLEN_BIT  = 11;
  localparam int CDIR_BIT  = 8;
  localparam int EN_BIT    = 7;
  localparam int AED_BIT   = 6;
  localparam int CPERM_BIT = 5;
  // writable bits: 31:24, 13, 11, 8, 7, 6, 5
  localparam logic [31:0] CTRL_WMASK = 32'hFF0029E0;
  localparam logic [31:0] CTRL_RST   = 32'h00000000;
  // event register bits
  localparam int EVT_START = 0;
  localparam int EVT_ABORT = 1;
  // transaction length in clock cycles
  localparam int XFER_CYCLES = 4;
  localparam int FIFO_DEPTH  = 32;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_DRAIN = 3'b100
  } dmacc_state_t;
endpackage

// file: logic/dmacc_top.sv
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ps
// Function
// R01: with matching and ignore enabled, a byte equal to ignore byte matches.
// R02: busy reads 1 while channel active or enabled, else 0.
// R03: bit 13 switches ignore-byte feature, effective only when matching.
// R04: bit 11 set selects two-byte pattern, cleared one-byte.
// R05: bit 8 set chains from channel n+1 completion, cleared from n-1; the code takes chain_done_lo when set, chain_done_hi when cleared.
// R06: chain direction is ignored unless chain permit is set.
// R07: bit 7 enables channel; clearing disables or suspends it.
// R08: bit 6 lets start and abort register while disabled.
// R09: bit 5 permits enabling by neighbour completion.
// R10: on disable, end current transaction before suspending, dropping busy.
// R11: bits 23:16, 14, 12 and 10:9 always read zero.
// R12: aliases at 0x4, 0x8, 0xC clear, set, invert written ones.
// R13: in two-byte mode ignore compare applies to each byte separately.
module dmacc_top
  import dmacc_pkg::*;
#(
  parameter int XFER_LEN = XFER_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        chain_done_hi,
  input  wire logic        chain_done_lo,
  input  wire logic        start_evt,
  input  wire logic        abort_evt,
  input  wire logic        src_valid,
  input  wire logic [7:0]  src_data,
  output logic             src_ready,
  output logic             dst_valid,
  output logic [7:0]       dst_data,
  input  wire logic        dst_ready,
  output logic             pat_match,
  output logic             xfer_done
);
  import dmacc_pkg::*;

  // longest drain seen from the cycle the run ends, plus one for margin
  localparam int DRAIN_MAX = XFER_LEN + 1;

  logic [31:0]  ctrl_r, ctrl_nxt;
  dmacc_state_t st_r, st_nxt;
  logic [7:0]   cyc_r, cyc_nxt;
  logic [7:0]   prev_r, prev_nxt;
  logic         pend_r, pend_nxt;
  logic         match_r, match_nxt;
  logic         done_r, done_nxt;
  logic         wr, rd_ok, chain_evt, evt_ok, start_ok, abort_ok;
  logic         busy, beat, byte_hit, pair_hit;
  logic [31:0]  rd_mux;
  logic [15:0]  pat_r, pat_nxt;
  logic [15:0]  cand;
  logic [1:0]   slot_hit;

  dmacc_fifo_if #(.W(8)) fq ();
  dmacc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .pclk    (pclk),
    .presetn (presetn),
    .f       (fq.fifo)
  );

  // per-byte compare; one function keeps the compare identical for both pattern bytes
  function automatic logic byte_eq(input logic [7:0] b,
                                   input logic [7:0] pat,
                                   input logic [31:0] c);
    byte_eq = (b == pat) ||
              (c[IGNEN_BIT] && b == c[IGN_LSB +: 8]); // see R01 R03
  endfunction

  function automatic logic [31:0] ctrl_read(input logic [31:0] c,
                                            input logic b);
    ctrl_read = c & CTRL_WMASK; // see R11
    ctrl_read[BUSY_BIT] = b; // see R02
  endfunction

  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr      = psel & penable & pwrite;
  assign busy    = (st_r != ST_IDLE) | ctrl_r[EN_BIT]; // see R02

  // neighbour completion only counts when chaining is permitted
  assign chain_evt = ctrl_r[CPERM_BIT] &&
                     (ctrl_r[CDIR_BIT] ? chain_done_lo
                                       : chain_done_hi); // see R05 R06 R09
  assign evt_ok   = ctrl_r[EN_BIT] | ctrl_r[AED_BIT]; // see R08
  assign start_ok = start_evt & evt_ok;
  assign abort_ok = abort_evt & evt_ok;

  // data path: bytes move source to fifo only while running
  assign fq.in_valid  = src_valid & (st_r == ST_RUN);
  assign fq.in_data   = src_data;
  assign src_ready    = fq.in_ready & (st_r == ST_RUN);
  assign dst_valid    = fq.out_valid;
  assign dst_data     = fq.out_data;
  assign fq.out_ready = dst_ready;
  assign beat         = fq.in_valid & fq.in_ready;

  // slot 0 is the byte on the bus, slot 1 the byte accepted before it;
  // each slot may be a don't-care on its own
  assign cand = {prev_r, src_data};
  for (genvar g = 0; g < 2; g++) begin : g_slot
    assign slot_hit[g] = byte_eq(cand[8*g +: 8], pat_r[8*g +: 8],
                                 ctrl_r); // see R13
  end
  assign byte_hit = slot_hit[0];
  assign pair_hit = &slot_hit; // see R04

  always_comb begin
    ctrl_nxt = ctrl_r;
    pat_nxt  = pat_r;
    if (wr) begin
      case (paddr)
        CTRL_OFF:     ctrl_nxt = pwdata & CTRL_WMASK;
        CTRL_CLR_OFF: ctrl_nxt = ctrl_r & ~(pwdata & CTRL_WMASK); // see R12
        CTRL_SET_OFF: ctrl_nxt = ctrl_r | (pwdata & CTRL_WMASK); // see R12
        CTRL_INV_OFF: ctrl_nxt = ctrl_r ^ (pwdata & CTRL_WMASK); // see R12
        CHAIN_OFF:    pat_nxt  = pwdata[15:0];
        default:      ctrl_nxt = ctrl_r;
      endcase
    end
    if (chain_evt) begin
      ctrl_nxt[EN_BIT] = 1'b1; // see R05 R09
    end
    ctrl_nxt[BUSY_BIT] = 1'b0;
  end

  always_comb begin
    st_nxt    = st_r;
    cyc_nxt   = cyc_r;
    prev_nxt  = prev_r;
    pend_nxt  = pend_r;
    match_nxt = 1'b0;
    done_nxt  = 1'b0;
    if (start_ok) begin
      pend_nxt = 1'b1; // see R08
    end
    if (abort_ok) begin
      pend_nxt = 1'b0; // see R08
    end
    case (st_r)
      ST_IDLE: begin
        cyc_nxt = '0;
        if (ctrl_r[EN_BIT] && pend_r && !abort_ok) begin // see R07
          st_nxt   = ST_RUN;
          // a start taken in this same cycle stays pending: set wins
          pend_nxt = start_ok;
        end
      end
      ST_RUN: begin
        if (beat) begin
          prev_nxt = src_data;
          if (ctrl_r[PLEN_BIT] ? pair_hit : byte_hit) begin // see R04
            match_nxt = 1'b1;
          end
        end
        cyc_nxt = 8'(cyc_r + 1'b1);
        if (abort_ok || !ctrl_r[EN_BIT]) begin
          st_nxt = ST_DRAIN; // see R10
        end else if (cyc_r == 8'(XFER_LEN - 1)) begin
          cyc_nxt = '0;
        end
      end
      ST_DRAIN: begin
        // the transaction in flight runs out before busy drops
        cyc_nxt = 8'(cyc_r + 1'b1);
        if (cyc_r >= 8'(XFER_LEN - 1)) begin // see R10
          st_nxt   = ST_IDLE;
          done_nxt = 1'b1;
          cyc_nxt  = '0;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r  <= CTRL_RST;
      pat_r   <= '0;
      st_r    <= ST_IDLE;
      cyc_r   <= '0;
      prev_r  <= '0;
      pend_r  <= 1'b0;
      match_r <= 1'b0;
      done_r  <= 1'b0;
    end else begin
      ctrl_r  <= ctrl_nxt;
      pat_r   <= pat_nxt;
      st_r    <= st_nxt;
      cyc_r   <= cyc_nxt;
      prev_r  <= prev_nxt;
      pend_r  <= pend_nxt;
      match_r <= match_nxt;
      done_r  <= done_nxt;
    end
  end

  always_comb begin
    case (paddr)
      CTRL_OFF, CTRL_CLR_OFF, CTRL_SET_OFF, CTRL_INV_OFF:
        rd_mux = ctrl_read(ctrl_r, busy);
      STAT_OFF:  rd_mux = {29'h0, st_r};
      CHAIN_OFF: rd_mux = {16'h0, pat_r};
      EVT_OFF:   rd_mux = {31'h0, pend_r};
      default:   rd_mux = 32'h00000000;
    endcase
  end

  assign rd_ok = psel & ~pwrite;
  assign prdata    = rd_ok ? rd_mux : 32'h00000000;
  assign pat_match = match_r;
  assign xfer_done = done_r;

  // a drain is a run that ends, a counted run-out, then idle with done
  sequence drain_entry_s;
    st_r == ST_RUN && (abort_ok || !ctrl_r[EN_BIT]);
  endsequence

  sequence drain_exit_s;
    st_r == ST_IDLE && xfer_done;
  endsequence

  busy_read_a: assert property ( // see R02
    @(posedge pclk) disable iff (!presetn)
    (rd_ok && paddr == CTRL_OFF)
      |-> prdata[BUSY_BIT] == (ctrl_r[EN_BIT] || st_r != ST_IDLE))
    else $error("busy bit wrong");
  resv_zero_a: assert property ( // see R11
    @(posedge pclk) disable iff (!presetn)
    (rd_ok && paddr <= CTRL_INV_OFF)
      |-> (prdata & ~CTRL_WMASK & ~32'h00008000) == 32'h00000000)
    else $error("reserved bits nonzero");
  set_alias_a: assert property ( // see R12
    @(posedge pclk) disable iff (!presetn)
    (wr && paddr == CTRL_SET_OFF) |=> ((ctrl_r & $past(pwdata)
      & CTRL_WMASK) == ($past(pwdata) & CTRL_WMASK)))
    else $error("set alias failed");
  clr_alias_a: assert property ( // see R12
    @(posedge pclk) disable iff (!presetn)
    (wr && paddr == CTRL_CLR_OFF && !chain_evt) |=>
      ((ctrl_r & $past(pwdata) & CTRL_WMASK) == 32'h00000000))
    else $error("clear alias failed");
  inv_alias_a: assert property ( // see R12
    @(posedge pclk) disable iff (!presetn)
    (wr && paddr == CTRL_INV_OFF && !chain_evt) |=>
      (ctrl_r == ($past(ctrl_r) ^ ($past(pwdata) & CTRL_WMASK))))
    else $error("invert alias failed");
  chain_en_a: assert property ( // see R05
    @(posedge pclk) disable iff (!presetn)
    (ctrl_r[CPERM_BIT] && ctrl_r[CDIR_BIT] && chain_done_lo)
      |=> ctrl_r[EN_BIT])
    else $error("chain no enable");
  chain_hi_a: assert property ( // see R05
    @(posedge pclk) disable iff (!presetn)
    (ctrl_r[CPERM_BIT] && !ctrl_r[CDIR_BIT] && chain_done_hi)
      |=> ctrl_r[EN_BIT])
    else $error("chain from higher neighbour lost");
  chain_gate_a: assert property ( // see R06 R09
    @(posedge pclk) disable iff (!presetn)
    (!ctrl_r[CPERM_BIT] && !ctrl_r[EN_BIT] && !wr) |=> !ctrl_r[EN_BIT])
    else $error("chain without permit");
  chain_dir_a: assert property ( // see R05 R06
    @(posedge pclk) disable iff (!presetn)
    (ctrl_r[CPERM_BIT] && !ctrl_r[EN_BIT] && !wr &&
      (ctrl_r[CDIR_BIT] ? !chain_done_lo : !chain_done_hi))
      |=> !ctrl_r[EN_BIT])
    else $error("chain from wrong neighbour");
  drain_len_a: assert property ( // see R10
    @(posedge pclk) disable iff (!presetn)
    (st_r == ST_DRAIN && cyc_r < 8'(XFER_LEN - 1)) |=> st_r == ST_DRAIN)
    else $error("drain too short");
  drain_done_a: assert property ( // see R10
    @(posedge pclk) disable iff (!presetn)
    drain_entry_s |-> ##[2:DRAIN_MAX] drain_exit_s)
    else $error("drain did not end");
  abort_drain_a: assert property ( // see R08 R10
    @(posedge pclk) disable iff (!presetn)
    drain_entry_s |=> st_r == ST_DRAIN)
    else $error("run did not drain");
  pend_set_a: assert property ( // see R08
    @(posedge pclk) disable iff (!presetn)
    (start_evt && evt_ok && !abort_evt) |=> pend_r)
    else $error("start event lost");
  start_gate_a: assert property ( // see R08
    @(posedge pclk) disable iff (!presetn)
    (start_evt && !ctrl_r[EN_BIT] && !ctrl_r[AED_BIT] && !pend_r)
      |=> !pend_r)
    else $error("event taken when disabled");
  run_en_a: assert property ( // see R07
    @(posedge pclk) disable iff (!presetn)
    (st_r == ST_IDLE && !ctrl_r[EN_BIT]) |=> st_r == ST_IDLE)
    else $error("ran while disabled");
  len_one_a: assert property ( // see R04
    @(posedge pclk) disable iff (!presetn)
    (st_r == ST_RUN && beat && !ctrl_r[PLEN_BIT] && src_data == pat_r[7:0])
      |=> pat_match)
    else $error("one-byte match missed");
  len_two_a: assert property ( // see R04 R13
    @(posedge pclk) disable iff (!presetn)
    (st_r == ST_RUN && beat && ctrl_r[PLEN_BIT] && prev_r == pat_r[15:8]
      && src_data == pat_r[7:0]) |=> pat_match)
    else $error("two-byte match missed");
  no_match_a: assert property ( // see R03 R04
    @(posedge pclk) disable iff (!presetn)
    (st_r == ST_RUN && beat && !ctrl_r[PLEN_BIT] && !ctrl_r[IGNEN_BIT]
      && src_data != pat_r[7:0]) |=> !pat_match)
    else $error("false one-byte match");
  ign_hit_a: assert property ( // see R01 R03 R04 R13
    @(posedge pclk) disable iff (!presetn)
    (st_r == ST_RUN && beat && !ctrl_r[PLEN_BIT] && ctrl_r[IGNEN_BIT]
      && src_data == ctrl_r[31:24] && ctrl_r[EN_BIT]) |=> pat_match)
    else $error("ignore byte missed");
endmodule

// file: tb/dmacc_stream_model.sv
`timescale 1ns/1ps
// far-side byte source and sink; an idle source line toggles so that a
// stale byte never passes for a fresh one
module dmacc_stream_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       stall,
  output logic            src_valid,
  output logic [7:0]      src_data,
  input  wire logic       src_ready,
  input  wire logic       dst_valid,
  input  wire logic [7:0] dst_data,
  output logic            dst_ready
);
  logic [7:0] tx_q[$];
  logic [7:0] rx_q[$];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_valid <= 1'b0;
      src_data  <= 8'h00;
      dst_ready <= 1'b0;
    end else begin
      if (src_valid && src_ready) begin
        void'(tx_q.pop_front());
      end
      if (tx_q.size() != 0) begin
        src_valid <= 1'b1;
        src_data  <= tx_q[0];
      end else begin
        src_valid <= 1'b0;
        src_data  <= ~src_data;
      end
      dst_ready <= !stall;
      if (dst_valid && dst_ready) begin
        rx_q.push_back(dst_data);
      end
    end
  end
endmodule

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import dmacc_pkg::*;
  localparam int XLEN = 6;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        hi, lo, start, abort, sv, sr, dv, dr, pmatch, xdone, stall;
  logic [7:0]  paddr, sd, dd;
  logic [31:0] pwdata, prdata, rq;
  logic        rq_err;
  logic [7:0]  bq[$];
  int          fails, tests_run, mcnt, dcnt;

  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    if (pmatch === 1'b1) mcnt++;
    if (xdone === 1'b1) dcnt++;
  end

  dmacc_top #(.XFER_LEN(XLEN)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .chain_done_hi(hi),
    .chain_done_lo(lo), .start_evt(start), .abort_evt(abort),
    .src_valid(sv), .src_data(sd), .src_ready(sr), .dst_valid(dv),
    .dst_data(dd), .dst_ready(dr), .pat_match(pmatch), .xfer_done(xdone));
  dmacc_stream_model m (
    .pclk(pclk), .presetn(presetn), .stall(stall), .src_valid(sv),
    .src_data(sd), .src_ready(sr), .dst_valid(dv), .dst_data(dd),
    .dst_ready(dr));

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic guard(input bit ok);
    if (!ok) begin
      fails++;
      $display("mismatch wait expected done seen timeout");
      report_and_stop();
    end
  endtask
  // each transfer starts just after an edge and leaves one idle edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    guard(n < 20);
    rq = prdata;
    rq_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic pls(input int k);
    {lo, hi, abort, start} <= 4'(1 << k);
    @(posedge pclk);
    {lo, hi, abort, start} <= 4'h0;
    @(posedge pclk);
  endtask

  task automatic t_regs;
    apb(0, CTRL_OFF, 0);
    chk("ctrl reset", CTRL_RST, rq);
    apb(1, 8'h1C, 32'hFFFFFFFF);
    apb(0, 8'h1C, 0);
    chk("unmapped", 32'h0, rq);
    chk("slverr", 32'h0, 32'(rq_err));
    apb(1, CTRL_OFF, 32'hFFFFFF7F);
    apb(0, CTRL_OFF, 0);
    chk("ctrl mask", CTRL_WMASK & 32'hFFFFFF7F, rq);
    apb(1, CTRL_CLR_OFF, 32'hFF000000);
    apb(1, CTRL_SET_OFF, 32'h12000000);
    apb(1, CTRL_INV_OFF, 32'h00002000);
    apb(0, CTRL_OFF, 0);
    chk("alias", 32'h12000960, rq);
    apb(1, CTRL_OFF, 0);
    $display("test regs done");
  endtask
  task automatic t_events;
    pls(0);
    apb(0, EVT_OFF, 0);
    chk("start ignored", 32'h0, rq);
    apb(1, CTRL_OFF, 32'h40);
    pls(0);
    apb(0, EVT_OFF, 0);
    chk("start kept", 32'h1, rq);
    pls(1);
    apb(0, EVT_OFF, 0);
    chk("abort kept", 32'h0, rq);
    apb(1, CTRL_OFF, 0);
    $display("test events done");
  endtask
  task automatic t_chain;
    logic ex;
    for (int k = 0; k < 8; k++) begin
      apb(1, CTRL_OFF, (32'(k[1]) << CDIR_BIT) | (32'(k[0]) << CPERM_BIT));
      pls(2 + k[2]);
      apb(0, CTRL_OFF, 0);
      ex = k[0] && k[1] == k[2];
      chk("chain", 32'(ex), 32'(rq[EN_BIT]));
      apb(1, CTRL_OFF, 0);
    end
    $display("test chain done");
  endtask
  task automatic run(input logic [31:0] c, input bit stl, input int em);
    int n;
    mcnt = 0;
    m.rx_q.delete();
    stall <= stl;
    foreach (bq[i]) m.tx_q.push_back(bq[i]);
    apb(1, CTRL_OFF, c | 32'h80);
    apb(0, CTRL_OFF, 0);
    chk("busy on", 32'h1, 32'(rq[BUSY_BIT]));
    pls(0);
    if (stl) begin
      repeat (80) @(posedge pclk);
      chk("fifo full", bq.size() - FIFO_DEPTH, m.tx_q.size());
      stall <= 1'b0;
    end
    for (n = 0; n < 400 && m.rx_q.size() < bq.size(); n++) @(posedge pclk);
    guard(n < 400);
    foreach (bq[i]) chk("byte", bq[i], m.rx_q[i]);
    chk("matches", em, mcnt);
    dcnt = 0;
    apb(1, CTRL_CLR_OFF, 32'h80);
    for (n = 0; n < XLEN + 4 && dcnt == 0; n++) @(posedge pclk);
    chk("drain end", 32'h1, dcnt);
    apb(0, CTRL_OFF, 0);
    chk("ctrl after", c & CTRL_WMASK, rq);
    apb(0, STAT_OFF, 0);
    chk("idle", 32'h1, rq);
    $display("test stream done");
  endtask

  initial begin
    pclk = 0;
    presetn = 0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {lo, hi, abort, start, stall} = '0;
    {fails, tests_run, mcnt, dcnt} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_events();
    t_chain();
    apb(1, CHAIN_OFF, 32'h0000A55A);
    bq = '{8'h00, 8'h11, 8'h5A, 8'h33};
    run(32'h0, 1'b0, 1);
    bq = '{8'h00, 8'hA5, 8'h5A, 8'h5A};
    run(32'h800, 1'b0, 1);
    bq = '{8'h00, 8'h33, 8'h5A, 8'h77, 8'hA5, 8'h33};
    run(32'h33002800, 1'b0, 2);
    run(32'h33000800, 1'b0, 0);
    run(32'h33002000, 1'b0, 3);
    bq.delete();
    for (int i = 0; i < 40; i++) bq.push_back(8'(i));
    run(32'h0, 1'b1, 0);
    report_and_stop();
  end
endmodule
